// >>> hdl/smc_pkg.sv
// package for the supply monitor control block
package smc_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] ADDR_DETECT_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_DETECT_LEVEL_MODE = 4'h4;
  localparam logic [3:0] ADDR_STATUS            = 4'h8;
  // control register fields
  localparam int         POS_WRITE_ENABLE       = 7;
  localparam int         POS_OUTPUT_MASK        = 1;
  localparam int         POS_BELOW_FLAG         = 0;
  // level/mode register fields
  localparam int         POS_MODE_SELECT        = 7;
  localparam int         POS_THRESHOLD_SELECT   = 0;
  // configuration byte fields
  localparam int         POS_CFG_GROUP_HI       = 7;
  localparam int         POS_CFG_GROUP_LO       = 5;
  localparam int         POS_CFG_FIXED_ONE      = 4;
  localparam int         POS_CFG_LEVEL_HI       = 3;
  localparam int         POS_CFG_LEVEL_LO       = 2;
  localparam int         POS_CFG_MODE_HI        = 1;
  localparam int         POS_CFG_MODE_LO        = 0;
  // reset values of level/mode register per mode, and of control register
  localparam logic [7:0] RST_LM_INT_RESET       = 8'h00;
  localparam logic [7:0] RST_LM_RESET           = 8'h81;
  localparam logic [7:0] RST_LM_INTERRUPT       = 8'h01;
  localparam logic [7:0] RST_CONTROL            = 8'h00;
  // configured mode field encodings
  localparam logic [1:0] CFG_MODE_INT_RESET     = 2'h2;
  localparam logic [1:0] CFG_MODE_RESET         = 2'h3;
  localparam logic [1:0] CFG_MODE_INTERRUPT     = 2'h1;
  // threshold stabilisation wait
  localparam int         CLK_MHZ                = 125;
  localparam int         SETTLE_US              = 400;
  localparam int         SETTLE_CYCLES          = SETTLE_US * CLK_MHZ;
  localparam int         SETTLE_W               = 16;

  typedef enum logic [1:0] {
    SMC_OFF       = 2'h0,
    SMC_INTERRUPT = 2'h1,
    SMC_RESET     = 2'h3,
    SMC_INT_RESET = 2'h2
  } smc_mode_type;

  // supply monitor state machine, gray codes along power-up path
  typedef enum logic [1:0] {
    SMC_ST_HOLD   = 2'h0,
    SMC_ST_RUN    = 2'h1,
    SMC_ST_LOW    = 2'h3
  } smc_state_type;

  // comparator outputs travel together
  typedef struct packed {
    logic below_single;
    logic below_high;
    logic below_low;
  } smc_cmp_type;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] adr;
    logic [7:0] dat;
  } smc_wb_req_type;
endpackage

// >>> hdl/smc_supply_monitor.sv
// supply monitor control: comparator sync, reset/interrupt generation, registers
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module smc_supply_monitor #(
  parameter int SETTLE_CYCLES = smc_pkg::SETTLE_CYCLES
) (
  input  wire  logic                   clk_i,
  input  wire  logic                   rst_i,
  input  wire  logic                   monitor_rst_i,
  input  wire  logic                   ce_i,
  input  wire  logic [7:0]             cfg_byte_i,
  input  wire  smc_pkg::smc_cmp_type   cmp_i,
  input  wire  logic                   irq_mask_clr_i,
  input  wire  logic                   wb_cyc_i,
  input  wire  logic                   wb_stb_i,
  input  wire  logic                   wb_we_i,
  input  wire  logic [3:0]             wb_adr_i,
  input  wire  logic [3:0]             wb_sel_i,
  input  wire  logic [31:0]            wb_dat_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  output logic                         monitor_rst_o,
  output logic                         low_supply_irq_o,
  output logic                         low_supply_irq_mask_o,
  output logic [2:0]                   threshold_group_o,
  output logic [1:0]                   threshold_level_o,
  output logic                         threshold_select_o
);

  //////////////////////////////////////////////////////////////////////////
  // configuration decode
  smc_pkg::smc_mode_type cfg_mode;
  logic                  monitor_off;

  always_comb begin
    monitor_off = cfg_byte_i[smc_pkg::POS_CFG_GROUP_HI] & cfg_byte_i[smc_pkg::POS_CFG_MODE_LO];
    cfg_mode = smc_pkg::smc_mode_type'(cfg_byte_i[smc_pkg::POS_CFG_MODE_HI:smc_pkg::POS_CFG_MODE_LO]);
    if (monitor_off) begin
      cfg_mode = smc_pkg::SMC_OFF;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // comparator synchroniser; first stage read only by second
  smc_pkg::smc_cmp_type cmp_meta;
  smc_pkg::smc_cmp_type cmp_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // start as below, so hold waits for real samples
      cmp_meta <= '1;
      cmp_sync <= '1;
    end else if (ce_i) begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers and state
  logic                    write_enable;
  logic                    mode_select;
  logic                    threshold_select;
  logic                    irq_mask;
  logic                    irq_pend;
  logic                    mon_rst;
  logic                    ack;
  logic [31:0]             rdata;
  logic [smc_pkg::SETTLE_W-1:0] settle_cnt;
  smc_pkg::smc_state_type  state;

  logic                    next_write_enable;
  logic                    next_mode_select;
  logic                    next_threshold_select;
  logic                    next_irq_mask;
  logic                    next_irq_pend;
  logic                    next_mon_rst;
  logic                    next_ack;
  logic [31:0]             next_rdata;
  logic [smc_pkg::SETTLE_W-1:0] next_settle_cnt;
  smc_pkg::smc_state_type  next_state;

  logic below_sel;
  logic below_flag;
  logic output_mask;
  logic wr_go;
  logic rd_go;
  logic [7:0] wbyte;

  always_comb begin
    if (cfg_mode == smc_pkg::SMC_INT_RESET) begin
      // hold always releases against the high threshold
      below_sel = (threshold_select && state != smc_pkg::SMC_ST_HOLD) ? cmp_sync.below_low : cmp_sync.below_high;
    end else begin
      below_sel = cmp_sync.below_single;
    end
    below_flag = below_sel & (cfg_mode != smc_pkg::SMC_OFF);
    output_mask = write_enable | (settle_cnt != '0);
    wr_go = wb_cyc_i & wb_stb_i & ~ack & wb_we_i & wb_sel_i[0];
    rd_go = wb_cyc_i & wb_stb_i & ~ack & ~wb_we_i;
    wbyte = wb_dat_i[7:0];
  end

  // next-state logic for registers, monitor fsm and bus
  always_comb begin
    next_write_enable     = write_enable;
    next_mode_select      = mode_select;
    next_threshold_select = threshold_select;
    next_irq_mask         = irq_mask;
    next_irq_pend         = 1'b0;
    next_mon_rst          = mon_rst;
    next_state            = state;
    next_settle_cnt       = (settle_cnt != '0) ? settle_cnt - 1'b1 : settle_cnt;
    next_ack              = wb_cyc_i & wb_stb_i & ~ack;
    next_rdata            = '0;

    // bus reads; unmapped addresses read zero
    if (rd_go) begin
      unique case (wb_adr_i)
        smc_pkg::ADDR_DETECT_CONTROL: begin
          next_rdata[smc_pkg::POS_WRITE_ENABLE] = write_enable;
          next_rdata[smc_pkg::POS_OUTPUT_MASK]  = output_mask;
          next_rdata[smc_pkg::POS_BELOW_FLAG]   = below_flag;
        end
        smc_pkg::ADDR_DETECT_LEVEL_MODE: begin
          next_rdata[smc_pkg::POS_MODE_SELECT]      = mode_select;
          next_rdata[smc_pkg::POS_THRESHOLD_SELECT] = threshold_select;
        end
        smc_pkg::ADDR_STATUS: begin
          next_rdata[0] = irq_mask;
          next_rdata[2:1] = cfg_mode;
        end
        default: next_rdata = '0;
      endcase
    end

    // bus writes; level/mode only in combined mode with enable
    if (wr_go) begin
      if (wb_adr_i == smc_pkg::ADDR_DETECT_CONTROL && cfg_mode == smc_pkg::SMC_INT_RESET) begin
        next_write_enable = wbyte[smc_pkg::POS_WRITE_ENABLE];
      end
      // writes accepted only in combined mode
      if (wb_adr_i == smc_pkg::ADDR_DETECT_LEVEL_MODE && cfg_mode == smc_pkg::SMC_INT_RESET && write_enable) begin
        next_mode_select      = wbyte[smc_pkg::POS_MODE_SELECT];
        next_threshold_select = wbyte[smc_pkg::POS_THRESHOLD_SELECT];
        if (wbyte[smc_pkg::POS_THRESHOLD_SELECT] != threshold_select) begin
          next_settle_cnt = smc_pkg::SETTLE_W'(SETTLE_CYCLES);
        end
      end
      if (wb_adr_i == smc_pkg::ADDR_STATUS) begin
        next_irq_mask = wbyte[0];
      end
    end
    if (irq_mask_clr_i) begin
      next_irq_mask = 1'b0;
    end

    // monitor sequencing
    unique case (state)
      smc_pkg::SMC_ST_HOLD: begin
        next_mon_rst = (cfg_mode != smc_pkg::SMC_OFF);
        if (cfg_mode == smc_pkg::SMC_OFF || !below_flag) begin
          next_mon_rst = 1'b0;
          next_state   = smc_pkg::SMC_ST_RUN;
          if (cfg_mode == smc_pkg::SMC_INT_RESET) begin
            next_threshold_select = 1'b0;
            next_mode_select      = 1'b0;
          end
        end
      end
      smc_pkg::SMC_ST_RUN: begin
        if (!output_mask && below_flag) begin
          unique case (cfg_mode)
            smc_pkg::SMC_RESET: begin
              next_mon_rst = 1'b1;
              next_state   = smc_pkg::SMC_ST_HOLD;
            end
            smc_pkg::SMC_INTERRUPT: begin
              next_irq_pend = 1'b1;
              next_state    = smc_pkg::SMC_ST_LOW;
            end
            smc_pkg::SMC_INT_RESET: begin
              if (mode_select) begin
                next_mon_rst = 1'b1;
                next_state   = smc_pkg::SMC_ST_HOLD;
              end else begin
                next_irq_pend = 1'b1;
                next_threshold_select = 1'b1;
                next_mode_select      = 1'b1;
                next_settle_cnt       = smc_pkg::SETTLE_W'(SETTLE_CYCLES);
                next_state            = smc_pkg::SMC_ST_LOW;
              end
            end
            default: next_state = smc_pkg::SMC_ST_RUN;
          endcase
        end
      end
      smc_pkg::SMC_ST_LOW: begin
        if (cfg_mode == smc_pkg::SMC_INTERRUPT && !below_flag) begin
          next_irq_pend = 1'b1;
          next_state    = smc_pkg::SMC_ST_RUN;
        end else if (cfg_mode == smc_pkg::SMC_INT_RESET) begin
          if (mode_select && threshold_select && !output_mask && below_flag) begin
            next_mon_rst = 1'b1;
            next_state   = smc_pkg::SMC_ST_HOLD;
          end else if (!mode_select) begin
            next_state = smc_pkg::SMC_ST_RUN;
          end
        end else if (cfg_mode != smc_pkg::SMC_INTERRUPT) begin
          next_state = smc_pkg::SMC_ST_RUN;
        end
      end
      default: next_state = smc_pkg::SMC_ST_HOLD;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state registers; chip reset vs monitor-caused reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask     <= 1'b1;
      write_enable <= smc_pkg::RST_CONTROL[smc_pkg::POS_WRITE_ENABLE];
      settle_cnt   <= '0;
      irq_pend     <= 1'b0;
      mon_rst      <= 1'b1;
      state        <= smc_pkg::SMC_ST_HOLD;
      ack          <= 1'b0;
      rdata        <= '0;
      if (!monitor_rst_i) begin
        unique case (cfg_mode)
          smc_pkg::SMC_RESET: begin
            mode_select      <= smc_pkg::RST_LM_RESET[smc_pkg::POS_MODE_SELECT];
            threshold_select <= smc_pkg::RST_LM_RESET[smc_pkg::POS_THRESHOLD_SELECT];
          end
          smc_pkg::SMC_INTERRUPT: begin
            mode_select      <= smc_pkg::RST_LM_INTERRUPT[smc_pkg::POS_MODE_SELECT];
            threshold_select <= smc_pkg::RST_LM_INTERRUPT[smc_pkg::POS_THRESHOLD_SELECT];
          end
          default: begin
            mode_select      <= smc_pkg::RST_LM_INT_RESET[smc_pkg::POS_MODE_SELECT];
            threshold_select <= smc_pkg::RST_LM_INT_RESET[smc_pkg::POS_THRESHOLD_SELECT];
          end
        endcase
      end
    end else if (ce_i) begin
      write_enable     <= next_write_enable;
      mode_select      <= next_mode_select;
      threshold_select <= next_threshold_select;
      irq_mask         <= next_irq_mask;
      irq_pend         <= next_irq_pend;
      mon_rst          <= next_mon_rst;
      settle_cnt       <= next_settle_cnt;
      state            <= next_state;
      ack              <= next_ack;
      rdata            <= next_rdata;
    end
  end

  // outputs straight from flip-flops; config fields pass for threshold selection
  // group and level to analog selector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      threshold_group_o <= '0;
      threshold_level_o <= '0;
    end else if (ce_i) begin
      threshold_group_o <= cfg_byte_i[smc_pkg::POS_CFG_GROUP_HI:smc_pkg::POS_CFG_GROUP_LO];
      threshold_level_o <= cfg_byte_i[smc_pkg::POS_CFG_LEVEL_HI:smc_pkg::POS_CFG_LEVEL_LO];
    end
  end

  always_comb begin
    wb_ack_o              = ack;
    wb_dat_o              = rdata;
    monitor_rst_o         = mon_rst;
    low_supply_irq_o      = irq_pend;
    low_supply_irq_mask_o = irq_mask;
    threshold_select_o    = threshold_select;
  end

endmodule

`default_nettype wire

// >>> tb/smc_monitor.sv
// assertion checker watching the supply monitor control ports
`timescale 1ns/1ns
`default_nettype none
module smc_monitor (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 monitor_rst_i,
  input wire logic                 ce_i,
  input wire logic [7:0]           cfg_byte_i,
  input wire smc_pkg::smc_cmp_type cmp_i,
  input wire logic                 irq_mask_clr_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic                 monitor_rst_o,
  input wire logic                 low_supply_irq_o,
  input wire logic                 low_supply_irq_mask_o,
  input wire logic                 threshold_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // decoded modes; group bit 7 high with mode bit 0 set means the monitor is off
  wire md_rst = cfg_byte_i[1:0] == smc_pkg::CFG_MODE_RESET && !cfg_byte_i[7];
  wire md_int = cfg_byte_i[1:0] == smc_pkg::CFG_MODE_INTERRUPT && !cfg_byte_i[7];
  wire md_cmb = cfg_byte_i[1:0] == smc_pkg::CFG_MODE_INT_RESET;
  //////////////////////////////////////////////////////////////////////////////
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_low; (cmp_i.below_single && ce_i) [*5]; endsequence
  sequence s_high; (!cmp_i.below_single && ce_i) [*5]; endsequence
  property p_ack; s_take |=> s_pulse; endproperty
  property p_rst_out; $fell(rst_i) |-> monitor_rst_o && low_supply_irq_mask_o && !low_supply_irq_o; endproperty
  property p_lvl_rst;
    $fell(rst_i) && !$past(monitor_rst_i) && !cfg_byte_i[7]
      |-> threshold_select_o == (cfg_byte_i[1:0] != smc_pkg::CFG_MODE_INT_RESET);
  endproperty
  property p_rst_hold; md_rst ##0 s_low |-> monitor_rst_o; endproperty
  property p_rst_free; (md_rst || md_int) ##0 s_high |-> !monitor_rst_o; endproperty
  property p_irq_int; md_int && !monitor_rst_o && $changed(cmp_i.below_single) |-> ##[1:5] low_supply_irq_o; endproperty
  property p_irq_cmb; md_cmb && !monitor_rst_o && $rose(cmp_i.below_high) |-> ##[1:5] low_supply_irq_o; endproperty
  property p_irq_pulse; low_supply_irq_o |=> !low_supply_irq_o; endproperty
  property p_mask_clr; irq_mask_clr_i |=> !low_supply_irq_mask_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack late or longer than one cycle");
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  a_lvl_rst: assert property (p_lvl_rst) else $error("threshold select wrong after reset");
  a_rst_hold: assert property (p_rst_hold) else $error("no reset with supply low");
  a_rst_free: assert property (p_rst_free) else $error("reset kept with supply high");
  a_irq_int: assert property (p_irq_int) else $error("no irq on crossing");
  a_irq_cmb: assert property (p_irq_cmb) else $error("no irq below high threshold");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
  a_mask_clr: assert property (p_mask_clr) else $error("irq mask not cleared");
endmodule
`default_nettype wire

// >>> tb/smc_supply_model.sv
// behavioural supply comparators facing the monitor
`timescale 1ns/1ns
`default_nettype none
module smc_supply_model #(
  parameter int TH_SINGLE = 2500,
  parameter int TH_HIGH   = 2610,
  parameter int TH_LOW    = 2450
) (
  input  wire logic [15:0]          supply_mv_i,
  output var  smc_pkg::smc_cmp_type cmp_o
);
  // three fixed thresholds, all compared at once
  // outputs move a little after the supply, so they are async to the clock
  // continuous, so the levels are defined from 3 ns after time zero
  assign #3 cmp_o = '{below_single: supply_mv_i < TH_SINGLE, below_high: supply_mv_i < TH_HIGH,
                      below_low: supply_mv_i < TH_LOW};
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the supply monitor control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                 clk_i, rst_i, monitor_rst_i, ce_i, irq_mask_clr_i;
  logic                 wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]           wb_adr_i;
  logic [7:0]           cfg_byte_i, v;
  logic [31:0]          wb_dat_i, wb_dat_o;
  logic [15:0]          supply_mv;
  smc_pkg::smc_cmp_type cmp_i;
  logic                 monitor_rst_o, low_supply_irq_o, low_supply_irq_mask_o, threshold_select_o;
  logic [31:0]          exp_q[$];
  logic [7:0]           cfgs[3] = '{8'h5A, 8'h5F, 8'h5D};
  logic [7:0]           lmv[3] = '{8'h00, 8'h81, 8'h01};
  int                   n_fail, total_checks, n_irq, n0;
  smc_supply_model u_sup (.supply_mv_i(supply_mv), .cmp_o(cmp_i));
  smc_supply_monitor #(.SETTLE_CYCLES(8)) DUT (.clk_i, .rst_i, .monitor_rst_i, .ce_i, .cfg_byte_i, .cmp_i,
    .irq_mask_clr_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .monitor_rst_o, .low_supply_irq_o, .low_supply_irq_mask_o, .threshold_group_o(),
    .threshold_level_o(), .threshold_select_o);
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one classic cycle; a read notes its expected byte for the watcher
  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    wb(1'b0, a, 8'h00);
  endtask
  task automatic do_reset(input logic [7:0] cfg, input logic by_mon);
    rst_i <= 1'b1;
    monitor_rst_i <= by_mon;
    cfg_byte_i <= cfg;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    monitor_rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // bounded waits on the internal reset and on the irq count
  task automatic wait_rst(input logic lv);
    for (int n = 0; n < 100 && monitor_rst_o !== lv; n++) @(posedge clk_i);
    check(monitor_rst_o, lv);
    if (monitor_rst_o !== lv) give_verdict();
  endtask
  task automatic wait_irq(input int cnt);
    for (int n = 0; n < 100 && n_irq < cnt; n++) @(posedge clk_i);
    check(n_irq, cnt);
    if (n_irq < cnt) give_verdict();
  endtask
  // watcher: read data meets the oldest note at each read ack
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, exp_q.pop_front());
    if (low_supply_irq_o === 1'b1) n_irq++;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, monitor_rst_i, ce_i, irq_mask_clr_i} = 4'hA;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    cfg_byte_i = 8'h5A;
    supply_mv = 16'd3300;
    {n_fail, total_checks, n_irq} = '0;
    void'($urandom(32'hD9FF4B7A));
    // reset values for the interrupt, reset and combined modes (not off); bit 4 always one
    foreach (cfgs[i]) begin
      do_reset(cfgs[i], 1'b0);
      wait_rst(1'b0);
      rd(smc_pkg::ADDR_DETECT_LEVEL_MODE, lmv[i]);
      rd(smc_pkg::ADDR_STATUS, {5'h00, cfgs[i][1:0], 1'b1});
      rd(smc_pkg::ADDR_DETECT_CONTROL, 8'h00);
      rd(4'hC, 8'h00);
    end
    // interrupt mode: writes refused, irq both ways, mask clear
    wb(1'b1, smc_pkg::ADDR_DETECT_CONTROL, 8'h80);
    wb(1'b1, smc_pkg::ADDR_DETECT_LEVEL_MODE, 8'h00);
    rd(smc_pkg::ADDR_DETECT_LEVEL_MODE, 8'h01);
    n0 = n_irq;
    supply_mv <= 16'd2400;
    wait_irq(n0 + 1);
    rd(smc_pkg::ADDR_DETECT_CONTROL, 8'h01);
    check(monitor_rst_o, 1'b0);
    supply_mv <= 16'd3300;
    wait_irq(n0 + 2);
    irq_mask_clr_i <= 1'b1;
    @(posedge clk_i);
    irq_mask_clr_i <= 1'b0;
    rd(smc_pkg::ADDR_STATUS, 8'h02);
    // reset mode: reset follows the supply
    // external reset before dip
    do_reset(8'h5F, 1'b0);
    wait_rst(1'b0);
    // clock enable low freezes the monitor, so the drop waits
    ce_i <= 1'b0;
    supply_mv <= 16'd2400;
    repeat (10) @(posedge clk_i);
    check(monitor_rst_o, 1'b0);
    ce_i <= 1'b1;
    wait_rst(1'b1);
    rd(smc_pkg::ADDR_DETECT_CONTROL, 8'h01);
    supply_mv <= 16'd3300;
    wait_rst(1'b0);
    // combined mode: irq, hardware level update, reset, monitor reset keeps register
    do_reset(8'h5A, 1'b0);
    wait_rst(1'b0);
    n0 = n_irq;
    supply_mv <= 16'd2550;
    wait_irq(n0 + 1);
    rd(smc_pkg::ADDR_DETECT_LEVEL_MODE, 8'h81);
    supply_mv <= 16'd2400;
    wait_rst(1'b1);
    do_reset(8'h5A, 1'b1);
    rd(smc_pkg::ADDR_DETECT_LEVEL_MODE, 8'h81);
    supply_mv <= 16'd3300;
    wait_rst(1'b0);
    rd(smc_pkg::ADDR_DETECT_LEVEL_MODE, 8'h00);
    wb(1'b1, smc_pkg::ADDR_DETECT_CONTROL, 8'h80);
    rd(smc_pkg::ADDR_DETECT_CONTROL, 8'h82);
    repeat (4) begin
      v = 8'($urandom());
      wb(1'b1, smc_pkg::ADDR_DETECT_LEVEL_MODE, v);
      rd(smc_pkg::ADDR_DETECT_LEVEL_MODE, {v[7], 6'h00, v[0]});
    end
    // monitor off: external reset only, flag stays clear
    do_reset(8'hB1, 1'b0);
    supply_mv <= 16'd2400;
    wait_rst(1'b0);
    rd(smc_pkg::ADDR_DETECT_CONTROL, 8'h00);
    give_verdict();
  end
endmodule
bind smc_supply_monitor smc_monitor u_chk (.clk_i, .rst_i, .monitor_rst_i, .ce_i, .cfg_byte_i, .cmp_i,
  .irq_mask_clr_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .monitor_rst_o, .low_supply_irq_o, .low_supply_irq_mask_o,
  .threshold_select_o);
`default_nettype wire
